/* rtl/bstc_map.vh */
`ifndef BSTC_MAP_VH
`define BSTC_MAP_VH
// Instruction codes
`define BSTC_IR_W 3
`define BSTC_IR_EXTEST 3'h0
`define BSTC_IR_IDCODE 3'h1
`define BSTC_IR_SAMPLE 3'h2
`define BSTC_IR_CLAMP 3'h3
`define BSTC_IR_HIGHZ 3'h4
`define BSTC_IR_BYPASS 3'h7
// Fixed value captured in Capture-IR (low bits 01)
`define BSTC_IR_CAPTURE 3'h1
// Identification fields
`define BSTC_ID_W 32
`define BSTC_ID_MFR_LSB 1
`define BSTC_ID_DEV_LSB 12
`define BSTC_ID_VER_LSB 28
// Boundary-scan chain length
`define BSTC_BSR_W 46
`endif

/* rtl/bstc_tap.v */
// Functional notes
// - Capture-DR loads selected register, then shifts/exits
// - Shift-DR advances selected register toward output
// - Exit1-DR goes Update-DR or Pause-DR
// - Pause-DR holds registers, waits for mode-select
// - Exit2-DR goes Update-DR or Shift-DR
// - Update-DR latches outputs on falling edge
// - Select-IR-Scan holds; goes Capture-IR or reset
// - Capture-IR loads fixed instruction capture value
// - Shift-IR shifts instruction, other registers hold
// - Exit1-IR goes Pause-IR or Update-IR
// - Pause-IR suspends shifting, waits for mode-select
// - Exit2-IR high goes Update-IR, falling latch
// - Latched code becomes current instruction
// - Three-bit instruction shift and latched stages
// - Code 010 selects boundary register, samples
// - Code 111 routes through one-bit bypass
// - Code 000 drives outputs from boundary register
// - Code 011 clamps outputs, bypass in path
// - Code 100 floats outputs, bypass in path
// - Code 001 selects identification register
// - Test-Logic-Reset forces identification instruction
// - Identification value: 1, maker, device, version
// - Power-up in reset state, system normal
// - Select-DR-Scan holds; Capture-DR or Select-IR
// - Identification is 32-bit shift register only, no latch
`timescale 1ns/100ps
`include "bstc_map.vh"
module bstc_tap #(
  // Arbitrary identity values, not any real part
  parameter [10:0] MFR_ID = 11'h000,
  parameter [15:0] DEV_ID = 16'h0000,
  parameter [3:0] VER_ID = 4'h0
) (
  // System clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Test port pins
  input wire i_test_reset_n_pin,
  input wire i_test_clock_pin,
  input wire i_test_mode_select_pin,
  input wire i_test_data_in_pin,
  output reg o_test_data_out_pin,
  output reg o_test_data_out_oe,
  // Boundary cells to and from the core and pads
  input wire [`BSTC_BSR_W-1:0] i_bsr_capture,
  output reg [`BSTC_BSR_W-1:0] o_bsr_update,
  // Pad control: take pins from boundary latch / float them
  output wire o_pins_from_bsr,
  output wire o_pins_highz,
  // Current state and instruction
  output reg [3:0] o_tap_state,
  output reg [`BSTC_IR_W-1:0] o_instruction
);
  localparam [3:0] ST_RESET = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SHIFT_DR = 4'h4;
  localparam [3:0] ST_EXIT1_DR = 4'h5;
  localparam [3:0] ST_PAUSE_DR = 4'h6;
  localparam [3:0] ST_EXIT2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'ha;
  localparam [3:0] ST_SHIFT_IR = 4'hb;
  localparam [3:0] ST_EXIT1_IR = 4'hc;
  localparam [3:0] ST_PAUSE_IR = 4'hd;
  localparam [3:0] ST_EXIT2_IR = 4'he;
  localparam [3:0] ST_UPD_IR = 4'hf;
  localparam [1:0] SEL_BYP = 2'h0;
  localparam [1:0] SEL_BSR = 2'h1;
  localparam [1:0] SEL_ID = 2'h2;

  wire [`BSTC_ID_W-1:0] id_value = {VER_ID, DEV_ID, MFR_ID, 1'b1};

  // Data register selected by an instruction
  function [1:0] dr_select;
    input [`BSTC_IR_W-1:0] ir;
    begin
      case (ir)
        `BSTC_IR_EXTEST: dr_select = SEL_BSR;
        `BSTC_IR_SAMPLE: dr_select = SEL_BSR;
        `BSTC_IR_IDCODE: dr_select = SEL_ID;
        default: dr_select = SEL_BYP;
      endcase
    end
  endfunction

  // Pins from the tester's domain, in one vector
  wire [3:0] pin_raw = {i_test_reset_n_pin, i_test_clock_pin, i_test_mode_select_pin, i_test_data_in_pin};
  wire [3:0] pin_sync;
  reg tck_prev;

  // Two flops per pin; first stage is read only by the second
  // Reset pin synchronised too, so state and registers agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg stage_a;
      reg stage_b;
      always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
        end else begin
          stage_a <= pin_raw[gi];
          stage_b <= stage_a;
        end
      end
      assign pin_sync[gi] = stage_b;
    end
  endgenerate

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= pin_sync[2];
    end
  end
  wire tck = pin_sync[2];
  wire tms = pin_sync[1];
  wire tdi = pin_sync[0];
  // Test-clock phases shorter than one system clock can be lost
  wire tck_rise = tck & ~tck_prev;
  wire tck_fall = ~tck & tck_prev;
  wire trst_n = pin_sync[3];

  reg [3:0] next_state;
  // State moves, applied on each rising edge
  always @* begin
    case (o_tap_state)
      ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  end

  reg [`BSTC_IR_W-1:0] ir_shift;
  reg [`BSTC_ID_W-1:0] id_shift;
  reg [`BSTC_BSR_W-1:0] bsr_shift;
  reg bypass_bit;
  wire [1:0] sel = dr_select(o_instruction);

  // reset pin forces state, system reset too
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tap_state <= ST_RESET;
    end else if (!trst_n) begin
      o_tap_state <= ST_RESET;
    end else if (tck_rise) begin
      o_tap_state <= next_state;
    end
  end

  // Rising edges that act on the test registers
  wire live_rise = trst_n & tck_rise;
  wire cap_dr = live_rise & (o_tap_state == ST_CAP_DR);
  wire shift_dr = live_rise & (o_tap_state == ST_SHIFT_DR);

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ir_shift <= {`BSTC_IR_W{1'b0}};
    end else if (live_rise && o_tap_state == ST_CAP_IR) begin
      ir_shift <= `BSTC_IR_CAPTURE;
    end else if (live_rise && o_tap_state == ST_SHIFT_IR) begin
      ir_shift <= {tdi, ir_shift[`BSTC_IR_W-1:1]};
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      id_shift <= {`BSTC_ID_W{1'b0}};
    end else if (cap_dr && sel == SEL_ID) begin
      id_shift <= id_value;
    end else if (shift_dr && sel == SEL_ID) begin
      id_shift <= {tdi, id_shift[`BSTC_ID_W-1:1]};
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bsr_shift <= {`BSTC_BSR_W{1'b0}};
    end else if (cap_dr && sel == SEL_BSR) begin
      bsr_shift <= i_bsr_capture;
    end else if (shift_dr && sel == SEL_BSR) begin
      bsr_shift <= {tdi, bsr_shift[`BSTC_BSR_W-1:1]};
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bypass_bit <= 1'b0;
    end else if (cap_dr && sel == SEL_BYP) begin
      bypass_bit <= 1'b0;
    end else if (shift_dr && sel == SEL_BYP) begin
      bypass_bit <= tdi;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_instruction <= `BSTC_IR_IDCODE;
    end else if (!trst_n || o_tap_state == ST_RESET) begin
      o_instruction <= `BSTC_IR_IDCODE;
    end else if (tck_fall && o_tap_state == ST_UPD_IR) begin
      o_instruction <= ir_shift;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bsr_update <= {`BSTC_BSR_W{1'b0}};
    end else if (trst_n && tck_fall && o_tap_state == ST_UPD_DR && sel == SEL_BSR) begin
      o_bsr_update <= bsr_shift;
    end
  end

  // Output changes on falling edge, as the tester samples on rising
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_test_data_out_pin <= 1'b0;
      o_test_data_out_oe <= 1'b0;
    end else if (!trst_n || o_tap_state == ST_RESET) begin
      o_test_data_out_oe <= 1'b0;
    end else if (tck_fall) begin
      o_test_data_out_oe <= (o_tap_state == ST_SHIFT_DR) || (o_tap_state == ST_SHIFT_IR);
      if (o_tap_state == ST_SHIFT_IR) begin
        o_test_data_out_pin <= ir_shift[0];
      end else begin
        case (sel)
          SEL_BSR: o_test_data_out_pin <= bsr_shift[0];
          SEL_ID: o_test_data_out_pin <= id_shift[0];
          default: o_test_data_out_pin <= bypass_bit;
        endcase
      end
    end
  end

  assign o_pins_from_bsr = (o_instruction == `BSTC_IR_EXTEST) || (o_instruction == `BSTC_IR_CLAMP);
  assign o_pins_highz = (o_instruction == `BSTC_IR_HIGHZ);
endmodule

/* test/bstc_tap_checker.sv */
`timescale 1ns/100ps
`include "bstc_map.vh"
module bstc_tap_checker (
  // Clock and resets
  input wire i_clk,
  input wire i_resetn,
  input wire i_test_reset_n_pin,
  // Watched outputs
  input wire o_test_data_out_oe,
  input wire [`BSTC_BSR_W-1:0] o_bsr_update,
  input wire o_pins_from_bsr,
  input wire o_pins_highz,
  input wire [3:0] o_tap_state,
  input wire [`BSTC_IR_W-1:0] o_instruction
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  test_reset_a: assert property ($fell(i_test_reset_n_pin) |-> ##[1:6] o_tap_state == 4'h0)
    else $error("test reset missed");
  reset_idcode_a: assert property (o_tap_state == 4'h0 [*3] |-> o_instruction == `BSTC_IR_IDCODE)
    else $error("reset instruction wrong");
  pins_bsr_a: assert property ($rose(o_pins_from_bsr) |-> o_tap_state == 4'hf)
    else $error("pin source changed outside update");
  pins_float_a: assert property ($rose(o_pins_highz) |-> o_tap_state == 4'hf)
    else $error("pin float changed outside update");
  instr_hold_a: assert property ($changed(o_instruction) |-> o_tap_state == 4'hf || o_tap_state == 4'h0)
    else $error("instruction moved");
  dr_latch_a: assert property ($changed(o_bsr_update) |-> o_tap_state == 4'h8 || o_tap_state == 4'h0)
    else $error("boundary latch moved");
  shift_drive_a: assert property ($rose(o_test_data_out_oe) |-> o_tap_state == 4'h4 || o_tap_state == 4'hb)
    else $error("serial out enabled");
  pause_exit_a: assert property ($past(o_tap_state) == 4'h6 && o_tap_state != 4'h6 |-> o_tap_state inside {4'h7, 4'h0})
    else $error("pause left wrongly");
endmodule
bind bstc_tap bstc_tap_checker i_chk (.i_clk, .i_resetn, .i_test_reset_n_pin, .o_test_data_out_oe,
  .o_bsr_update, .o_pins_from_bsr, .o_pins_highz, .o_tap_state, .o_instruction);

/* test/bstc_tester.sv */
`timescale 1ns/100ps
module bstc_tester (
  // Test port pins
  output reg o_tck,
  output reg o_tms,
  output reg o_tdi
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  task automatic low(input bit m, input bit d);
    o_tms = m;
    o_tdi = d;
    o_tck = 1'b0;
    #80;
  endtask
  task automatic high;
    o_tck = 1'b1;
    #80;
  endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/100ps
`include "bstc_map.vh"
module tb_top;
  localparam [63:0] T0 = 64'h1bdd_bba1_4664_4311;
  localparam [63:0] T1 = 64'h2fef_cc02_8785_5920;
  // Arbitrary identity fields
  localparam [31:0] ID = {4'h9, 16'h1c3e, 11'h2a5, 1'b1};
  reg i_clk = 0, i_resetn = 0, trst_n = 1;
  reg [45:0] cap = 0;
  wire tck, tms, tdi, tdo, oe, from_bsr, highz;
  wire [45:0] upd;
  wire [3:0] st;
  wire [2:0] ins;
  int errors, total_checks, m_st;
  reg [2:0] m_ir, m_ish;
  bit [31:0] lfsr = 32'h5b4b_4c80;
  bstc_tap #(.MFR_ID(ID[11:1]), .DEV_ID(ID[27:12]), .VER_ID(ID[31:28])) i_bstc_tap (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_test_reset_n_pin(trst_n), .i_test_clock_pin(tck), .i_test_mode_select_pin(tms),
    .i_test_data_in_pin(tdi), .o_test_data_out_pin(tdo), .o_test_data_out_oe(oe), .i_bsr_capture(cap),
    .o_bsr_update(upd), .o_pins_from_bsr(from_bsr), .o_pins_highz(highz), .o_tap_state(st), .o_instruction(ins));
  bstc_tester i_bstc_tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  initial forever #2.5 i_clk = ~i_clk;
  function automatic bit [31:0] nx(bit [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [45:0] s, input logic [45:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One test-clock period against the model
  task automatic step(input bit m, input bit d, output bit o);
    i_bstc_tester.low(m, d);
    if (m_st == 15) m_ir = m_ish;
    if (m_st == 0) m_ir = 3'h1;
    chk("state", st, m_st);
    chk("instr", ins, m_ir);
    chk("oe", oe, m_st == 4 || m_st == 11);
    if (m_st == 11) chk("ir out", tdo, m_ish[0]);
    o = tdo;
    if (m_st == 10) m_ish = 3'h1;
    if (m_st == 11) m_ish = {d, m_ish[2:1]};
    m_st = (m ? T1 : T0) >> (4 * m_st) & 15;
    i_bstc_tester.high();
  endtask
  task automatic scan(input bit ir, input int n, input logic [45:0] di, output logic [45:0] dq);
    bit o;
    dq = 0;
    step(1, 0, o);
    if (ir) step(1, 0, o);
    step(0, 0, o);
    step(0, 0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, di[i], o);
      dq[i] = o;
    end
    step(1, 0, o);
    step(0, 0, o);
  endtask
  initial begin
    #400_000;
    errors++;
    print_verdict;
  end
  initial begin
    bit o;
    logic [45:0] q, p, u;
    logic [2:0] c;
    m_st = 0;
    m_ir = 3'h1;
    m_ish = 3'h1;
    repeat (5) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 chk("instr", ins, 3'h1);
    step(0, 0, o);
    scan(0, 32, {14'h0, lfsr}, q);
    chk("idcode", q[31:0], ID);
    $display("test idcode done");
    // Codes 0,1,2,3,4,7 in 3-bit slots
    for (int k = 0; k < 6; k++) begin
      c = 18'h3_c688 >> (3 * k);
      scan(1, 3, c, q);
      chk("ir capture", q[2:0], 3'h1);
      chk("from bsr", from_bsr, c == 0 || c == 3);
      chk("highz", highz, c == 4);
      lfsr = nx(nx(lfsr));
      p = {lfsr[13:0], nx(lfsr)};
      cap = {p[31:0], p[45:32]};
      u = upd;
      scan(0, 46, p, q);
      if (c == 0 || c == 2) begin
        chk("bsr out", q, cap);
        chk("bsr latch", upd, p);
      end else if (c == 1) chk("id", q[31:0], ID);
      else begin
        chk("bypass", q, {p[44:0], 1'b0});
        chk("latch held", upd, u);
      end
    end
    $display("test instructions done");
    for (int k = 0; k < 7; k++) step(7'h25 >> k & 1, 0, o);
    trst_n = 1'b0;
    repeat (8) @(posedge i_clk);
    #1 chk("trst state", st, 4'h0);
    chk("trst instr", ins, 3'h1);
    trst_n = 1'b1;
    m_st = 0;
    $display("test reset pin done");
    for (int k = 0; k < 80; k++) begin
      lfsr = nx(lfsr);
      step(lfsr[0], lfsr[7], o);
    end
    $display("test random walk done");
    print_verdict;
  end
endmodule
